// *** hw/avc_defines.svh ***
// register offsets, field positions, codes and reset values of the command block
`ifndef AVC_DEFINES_SVH
`define AVC_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets on the register bus
// ----------------------------------------------------------------------
`define AVC_OFF_CMD     8'h00
`define AVC_OFF_SCNT    8'h04
`define AVC_OFF_SNUM    8'h08
`define AVC_OFF_CYLL    8'h0C
`define AVC_OFF_CYLH    8'h10
`define AVC_OFF_DEVCTL  8'h14
`define AVC_OFF_ERR     8'h18
`define AVC_OFF_STAT    8'h1C
`define AVC_OFF_DATA    8'h20
`define AVC_OFF_SEC     8'h24

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AVC_ST_BSY      7
`define AVC_ST_RDY      6
`define AVC_ST_DSC      4
`define AVC_ST_DRQ      3
`define AVC_ST_ERR      0
`define AVC_ER_UNC      6
`define AVC_ER_ABT      2
`define AVC_ER_T0N      1
`define AVC_HOB_BIT     7
`define AVC_ID_BIT      0
`define AVC_SEC_EN_BIT  0

// ----------------------------------------------------------------------
// command codes, reset values, counts
// ----------------------------------------------------------------------
`define AVC_CMD_VFY_EXT 8'h42
`define AVC_CMD_RECAL   4'h1
`define AVC_CMD_SEC_DIS 8'hF6
`define AVC_STAT_RST    8'h50
`define AVC_ERR_RST     8'h00
`define AVC_CNT_FULL    17'h10000
`define AVC_WORD_LAST   8'hFF

`endif

// *** hw/avc_pkg.sv ***
// types shared by the command block files
`default_nettype none

package avc_pkg;
    typedef logic [47:0] avc_lba_t;
    typedef logic [7:0]  avc_byte_t;
    typedef enum logic [2:0] {
        AVC_IDLE, AVC_VFY_REQ, AVC_VFY_WAIT, AVC_SEEK_WAIT, AVC_PW_DATA, AVC_PW_EVAL
    } avc_state_t;
endpackage

`default_nettype wire

// *** hw/avc_pw_cmp.sv ***
// running compare of the password words against the stored passwords
`default_nettype none

module avc_pw_cmp #(
    parameter int PW_WORDS = 16
) (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    // parameter sector words
    input  wire logic                    word_valid_i,
    input  wire logic [7:0]              word_idx_i,
    input  wire logic [15:0]             word_i,
    // stored passwords
    input  wire logic [16*PW_WORDS-1:0]  user_pw_i,
    input  wire logic [16*PW_WORDS-1:0]  master_pw_i,
    // results, valid once the last word is in
    output logic                         user_ok_o,
    output logic                         master_ok_o
);
    logic       user_ok_r;
    logic       user_ok_nxt;
    logic       master_ok_r;
    logic       master_ok_nxt;
    logic [7:0] sel;

    // word 0 restarts the compare; only words 1..PW_WORDS count
    always_comb begin
        user_ok_nxt   = user_ok_r;
        master_ok_nxt = master_ok_r;
        sel           = word_idx_i - 8'h01;
        if (word_valid_i) begin
            if (word_idx_i == 8'h00) begin
                user_ok_nxt   = 1'b1;
                master_ok_nxt = 1'b1;
            end else if (word_idx_i <= 8'(PW_WORDS)) begin
                user_ok_nxt   = user_ok_r & (word_i == user_pw_i[sel*16 +: 16]);
                master_ok_nxt = master_ok_r & (word_i == master_pw_i[sel*16 +: 16]);
            end
        end
    end

    // result flags
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            user_ok_r   <= 1'b0;
            master_ok_r <= 1'b0;
        end else begin
            user_ok_r   <= user_ok_nxt;
            master_ok_r <= master_ok_nxt;
        end
    end

    assign user_ok_o   = user_ok_r;
    assign master_ok_o = master_ok_r;
endmodule

`default_nettype wire

// *** hw/avc_core.sv ***
// command handling for extended read verify, recalibrate and password disable
//
// Functional notes
// - count: current byte low, previous byte high
// - zero count verifies 65,536 sectors
// - 48-bit start LBA from current/previous bytes
// - failing LBA low bytes shown when HOB clear
// - failing LBA high bytes shown when HOB set
// - any 1xh command seeks to cylinder 0
// - failed seek sets T0N and status error
// - F6h requests one parameter sector first
// - identifier picks user or master password
// - matching password turns security lock off
// - disable keeps stored master password unchanged
// - user id while disabled aborts command
`include "avc_defines.svh"
`default_nettype none

module avc_core #(
    parameter int PW_WORDS = 16
) (
    // clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    reset_i,
    // apb slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [7:0]              paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic [31:0]                  prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // media verify engine
    output logic                         vfy_req_o,
    output avc_pkg::avc_lba_t            vfy_lba_o,
    input  wire logic                    vfy_done_i,
    input  wire logic                    vfy_unc_i,
    // actuator seek
    output logic                         seek_req_o,
    input  wire logic                    seek_done_i,
    input  wire logic                    seek_fail_i,
    // stored passwords and lock state
    input  wire logic [16*PW_WORDS-1:0]  user_pw_i,
    input  wire logic [16*PW_WORDS-1:0]  master_pw_i,
    output logic                         sec_en_o
);
    import avc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    avc_state_t state_r, state_nxt;
    avc_byte_t  cur_r [4];      // 0 count, 1 sector, 2 cyl low, 3 cyl high
    avc_byte_t  cur_nxt [4];
    avc_byte_t  prv_r [4];
    avc_byte_t  prv_nxt [4];
    avc_byte_t  err_r, err_nxt;
    avc_byte_t  stat_r, stat_nxt;
    avc_lba_t   lba_r, lba_nxt;
    logic [16:0] cnt_r, cnt_nxt;
    logic [7:0]  wix_r, wix_nxt;
    logic        hob_r, hob_nxt;
    logic        pw_id_r, pw_id_nxt;
    logic        sec_en_r, sec_en_nxt;
    logic        vfy_req_r, vfy_req_nxt;
    logic        seek_req_r, seek_req_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        wr_acc;
    logic        rd_setup;
    logic        busy;
    logic        cmd_wr;
    logic        word_wr;
    logic        user_ok;
    logic        master_ok;
    logic        sel_ok;
    logic        mapped;
    int          idx;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // write lands on the edge that samples pready high
    assign wr_acc   = psel_i & penable_i & pready_r & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    assign busy     = stat_r[`AVC_ST_BSY] | stat_r[`AVC_ST_DRQ];
    assign cmd_wr   = wr_acc & ~busy & (paddr_i == `AVC_OFF_CMD);
    assign word_wr  = wr_acc & (state_r == AVC_PW_DATA) & (paddr_i == `AVC_OFF_DATA);
    assign mapped   = (paddr_i[1:0] == 2'b00) && (paddr_i <= `AVC_OFF_SEC);
    assign sel_ok   = pw_id_r ? master_ok : user_ok;

    avc_pw_cmp #(
        .PW_WORDS     (PW_WORDS)
    ) u_cmp (
        .clock_i      (clock_i),
        .reset_i      (reset_i),
        .word_valid_i (word_wr),
        .word_idx_i   (wix_r),
        .word_i       (pwdata_i[15:0]),
        .user_pw_i    (user_pw_i),
        .master_pw_i  (master_pw_i),
        .user_ok_o    (user_ok),
        .master_ok_o  (master_ok)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        cur_nxt      = cur_r;
        prv_nxt      = prv_r;
        err_nxt      = err_r;
        stat_nxt     = stat_r;
        lba_nxt      = lba_r;
        cnt_nxt      = cnt_r;
        wix_nxt      = wix_r;
        hob_nxt      = hob_r;
        pw_id_nxt    = pw_id_r;
        sec_en_nxt   = sec_en_r;
        vfy_req_nxt  = 1'b0;
        seek_req_nxt = 1'b0;
        pready_nxt   = psel_i & ~penable_i;
        pslverr_nxt  = psel_i & ~penable_i & ~mapped;
        prdata_nxt   = prdata_r;
        idx          = 0;

        // read data is captured in the setup cycle
        if (rd_setup) begin
            prdata_nxt = 32'h0000_0000;
            case (paddr_i)
                `AVC_OFF_SCNT, `AVC_OFF_SNUM, `AVC_OFF_CYLL, `AVC_OFF_CYLH: begin
                    idx = int'(paddr_i[4:2]) - 1;
                    prdata_nxt[7:0] = hob_r ? prv_r[idx] : cur_r[idx];
                end
                `AVC_OFF_DEVCTL: prdata_nxt[`AVC_HOB_BIT] = hob_r;
                `AVC_OFF_ERR:    prdata_nxt[7:0] = err_r;
                `AVC_OFF_STAT:   prdata_nxt[7:0] = stat_r;
                `AVC_OFF_SEC:    prdata_nxt[`AVC_SEC_EN_BIT] = sec_en_r;
                default:         prdata_nxt = 32'h0000_0000;
            endcase
        end

        // block registers shift current into previous; frozen while busy
        if (wr_acc && !busy) begin
            case (paddr_i)
                `AVC_OFF_SCNT, `AVC_OFF_SNUM, `AVC_OFF_CYLL, `AVC_OFF_CYLH: begin
                    idx          = int'(paddr_i[4:2]) - 1;
                    prv_nxt[idx] = cur_r[idx];
                    cur_nxt[idx] = pwdata_i[7:0];
                end
                `AVC_OFF_DEVCTL: hob_nxt = pwdata_i[`AVC_HOB_BIT];
                // writing the enable bit turns the security lock back on; a 0 is ignored
                `AVC_OFF_SEC: begin
                    if (pwdata_i[`AVC_SEC_EN_BIT]) begin
                        sec_en_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end

        // command decode
        if (cmd_wr) begin
            err_nxt                = `AVC_ERR_RST;
            stat_nxt[`AVC_ST_ERR]  = 1'b0;
            stat_nxt[`AVC_ST_BSY]  = 1'b1;
            if (pwdata_i[7:0] == `AVC_CMD_VFY_EXT) begin
                // start address from both byte sets
                lba_nxt = {prv_r[3], prv_r[2], prv_r[1], cur_r[3], cur_r[2], cur_r[1]};
                cnt_nxt = ({prv_r[0], cur_r[0]} == 16'h0000) ? `AVC_CNT_FULL
                                                             : {1'b0, prv_r[0], cur_r[0]};
                state_nxt = AVC_VFY_REQ;
            end else if (pwdata_i[7:4] == `AVC_CMD_RECAL) begin
                seek_req_nxt = 1'b1;
                state_nxt    = AVC_SEEK_WAIT;
            end else if (pwdata_i[7:0] == `AVC_CMD_SEC_DIS) begin
                stat_nxt[`AVC_ST_BSY] = 1'b0;
                stat_nxt[`AVC_ST_DRQ] = 1'b1;
                wix_nxt               = 8'h00;
                state_nxt             = AVC_PW_DATA;
            end else begin
                // unsupported code aborts at once
                err_nxt[`AVC_ER_ABT]  = 1'b1;
                stat_nxt[`AVC_ST_ERR] = 1'b1;
                stat_nxt[`AVC_ST_BSY] = 1'b0;
            end
        end

        case (state_r)
            AVC_VFY_REQ: begin
                vfy_req_nxt = 1'b1;
                state_nxt   = AVC_VFY_WAIT;
            end
            AVC_VFY_WAIT: begin
                if (vfy_done_i && vfy_unc_i) begin
                    // failing address into both byte sets
                    for (int i = 1; i < 4; i++) begin
                        cur_nxt[i] = lba_r[8*(i-1) +: 8];
                        prv_nxt[i] = lba_r[8*(i+2) +: 8];
                    end
                    cur_nxt[0]            = cnt_r[7:0];
                    prv_nxt[0]            = cnt_r[15:8];
                    err_nxt[`AVC_ER_UNC]  = 1'b1;
                    stat_nxt[`AVC_ST_ERR] = 1'b1;
                    stat_nxt[`AVC_ST_BSY] = 1'b0;
                    state_nxt             = AVC_IDLE;
                end else if (vfy_done_i) begin
                    lba_nxt = lba_r + 48'h1;
                    cnt_nxt = cnt_r - 17'h1;
                    if (cnt_r == 17'h1) begin
                        cur_nxt[0]            = 8'h00;
                        prv_nxt[0]            = 8'h00;
                        stat_nxt[`AVC_ST_BSY] = 1'b0;
                        state_nxt             = AVC_IDLE;
                    end else begin
                        state_nxt = AVC_VFY_REQ;
                    end
                end
            end
            AVC_SEEK_WAIT: begin
                if (seek_done_i) begin
                    err_nxt[`AVC_ER_T0N]  = seek_fail_i;
                    stat_nxt[`AVC_ST_ERR] = seek_fail_i;
                    stat_nxt[`AVC_ST_BSY] = 1'b0;
                    state_nxt             = AVC_IDLE;
                end
            end
            AVC_PW_DATA: begin
                if (word_wr) begin
                    if (wix_r == 8'h00) begin
                        pw_id_nxt = pwdata_i[`AVC_ID_BIT];
                    end
                    wix_nxt = wix_r + 8'h01;
                    if (wix_r == `AVC_WORD_LAST) begin
                        stat_nxt[`AVC_ST_DRQ] = 1'b0;
                        stat_nxt[`AVC_ST_BSY] = 1'b1;
                        state_nxt             = AVC_PW_EVAL;
                    end
                end
            end
            AVC_PW_EVAL: begin
                stat_nxt[`AVC_ST_BSY] = 1'b0;
                state_nxt             = AVC_IDLE;
                if (!pw_id_r && !sec_en_r) begin
                    err_nxt[`AVC_ER_ABT]  = 1'b1;
                    stat_nxt[`AVC_ST_ERR] = 1'b1;
                end else if (sel_ok) begin
                    sec_en_nxt = 1'b0;
                end else begin
                    err_nxt[`AVC_ER_ABT]  = 1'b1;
                    stat_nxt[`AVC_ST_ERR] = 1'b1;
                end
            end
            default: ;
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // security starts enabled until software says otherwise
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_r    <= AVC_IDLE;
            cur_r      <= '{default: 8'h00};
            prv_r      <= '{default: 8'h00};
            err_r      <= `AVC_ERR_RST;
            stat_r     <= `AVC_STAT_RST;
            lba_r      <= 48'h0;
            cnt_r      <= 17'h0;
            wix_r      <= 8'h00;
            hob_r      <= 1'b0;
            pw_id_r    <= 1'b0;
            sec_en_r   <= 1'b1;
            vfy_req_r  <= 1'b0;
            seek_req_r <= 1'b0;
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cur_r      <= cur_nxt;
            prv_r      <= prv_nxt;
            err_r      <= err_nxt;
            stat_r     <= stat_nxt;
            lba_r      <= lba_nxt;
            cnt_r      <= cnt_nxt;
            wix_r      <= wix_nxt;
            hob_r      <= hob_nxt;
            pw_id_r    <= pw_id_nxt;
            sec_en_r   <= sec_en_nxt;
            vfy_req_r  <= vfy_req_nxt;
            seek_req_r <= seek_req_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
        end
    end

    assign prdata_o   = prdata_r;
    assign pready_o   = pready_r;
    assign pslverr_o  = pslverr_r;
    assign vfy_req_o  = vfy_req_r;
    assign vfy_lba_o  = lba_r;
    assign seek_req_o = seek_req_r;
    assign sec_en_o   = sec_en_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    count_form_a: assert property (
        cmd_wr && pwdata_i[7:0] == `AVC_CMD_VFY_EXT && {prv_r[0], cur_r[0]} != 16'h0
        |=> cnt_r == {1'b0, $past(prv_r[0]), $past(cur_r[0])})
        else $error("sector count not formed from both bytes");
    zero_count_a: assert property (
        cmd_wr && pwdata_i[7:0] == `AVC_CMD_VFY_EXT && {prv_r[0], cur_r[0]} == 16'h0
        |=> cnt_r == 17'h10000 ##1 vfy_req_r)
        else $error("zero count not taken as full range");
    lba_form_a: assert property (
        cmd_wr && pwdata_i[7:0] == `AVC_CMD_VFY_EXT
        |=> lba_r == {$past(prv_r[3]), $past(prv_r[2]), $past(prv_r[1]),
                      $past(cur_r[3]), $past(cur_r[2]), $past(cur_r[1])})
        else $error("start address misassembled");
    fail_low_a: assert property (
        state_r == AVC_VFY_WAIT && vfy_done_i && vfy_unc_i
        |=> cur_r[1] == $past(lba_r[7:0]) && cur_r[3] == $past(lba_r[23:16])
            && err_r[`AVC_ER_UNC] && !stat_r[`AVC_ST_BSY])
        else $error("failing address low bytes wrong");
    fail_high_a: assert property (
        state_r == AVC_VFY_WAIT && vfy_done_i && vfy_unc_i
        |=> prv_r[1] == $past(lba_r[31:24]) && prv_r[3] == $past(lba_r[47:40]))
        else $error("failing address high bytes wrong");
    recal_any_a: assert property (
        cmd_wr && pwdata_i[7:4] == 4'h1
        |=> seek_req_r && state_r == AVC_SEEK_WAIT ##1 !seek_req_r)
        else $error("recalibrate code not accepted");
    track_zero_a: assert property (
        state_r == AVC_SEEK_WAIT && seek_done_i && seek_fail_i
        |=> err_r[`AVC_ER_T0N] && stat_r[`AVC_ST_ERR] && state_r == AVC_IDLE)
        else $error("seek failure not reported");
    data_req_a: assert property (
        cmd_wr && pwdata_i[7:0] == `AVC_CMD_SEC_DIS
        |=> stat_r[`AVC_ST_DRQ] && !stat_r[`AVC_ST_BSY] && state_r == AVC_PW_DATA)
        else $error("parameter sector not requested");
    unlock_ok_a: assert property (
        state_r == AVC_PW_EVAL && sel_ok && (pw_id_r || sec_en_r)
        |=> !sec_en_r && !stat_r[`AVC_ST_ERR])
        else $error("matching password did not unlock");
    user_abort_a: assert property (
        state_r == AVC_PW_EVAL && !pw_id_r && !sec_en_r
        |=> err_r[`AVC_ER_ABT] && stat_r[`AVC_ST_ERR])
        else $error("user id while disabled not aborted");
    bad_pw_a: assert property (
        state_r == AVC_PW_EVAL && !sel_ok && sec_en_r
        |=> sec_en_r && err_r[`AVC_ER_ABT])
        else $error("mismatch changed lock or missed abort");
endmodule

`default_nettype wire

// *** tb/avc_media_model.sv ***
// media verify and actuator responder facing the command block
`default_nettype none
module avc_media_model (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // requests from the block
    input  wire logic        vfy_req_i,
    input  wire logic [47:0] vfy_lba_i,
    input  wire logic        seek_req_i,
    // scenario controls
    input  wire logic [3:0]  delay_i,
    input  wire logic [47:0] bad_lba_i,
    input  wire logic        bad_en_i,
    input  wire logic        seek_bad_i,
    // answers
    output logic             vfy_done_o,
    output logic             vfy_unc_o,
    output logic             seek_done_o,
    output logic             seek_fail_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] vcnt_r;
    logic [4:0] scnt_r;
    // countdown per request; qualifiers toggle outside done so stale values never pass
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            vcnt_r      <= '0;
            scnt_r      <= '0;
            vfy_done_o  <= 1'b0;
            vfy_unc_o   <= 1'b0;
            seek_done_o <= 1'b0;
            seek_fail_o <= 1'b0;
        end else begin
            vfy_done_o  <= (vcnt_r == 5'h01);
            seek_done_o <= (scnt_r == 5'h01);
            vfy_unc_o   <= (vcnt_r == 5'h01) ? (bad_en_i && vfy_lba_i == bad_lba_i) : ~vfy_unc_o;
            seek_fail_o <= (scnt_r == 5'h01) ? seek_bad_i : ~seek_fail_o;
            vcnt_r <= vfy_req_i ? {1'b0, delay_i} + 5'h01 : vcnt_r - 5'(vcnt_r != 5'h00);
            scnt_r <= seek_req_i ? {1'b0, delay_i} + 5'h01 : scnt_r - 5'(scnt_r != 5'h00);
        end
    end
endmodule
`default_nettype wire

// *** tb/test_ata_verify_recal_secdisable.sv ***
// self-checking bench of the command block
`include "avc_defines.svh"
`default_nettype none
module test_ata_verify_recal_secdisable;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock_i, reset_i, psel, penable, pwrite, pready, rs, vreq, vdone, vunc;
    logic        sreq, sdone, sfail, sec_en, bad_en, seek_bad;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [47:0] vlba, bad_lba;
    logic [255:0] upw, mpw, pw;
    logic [3:0]  dly;
    int          n_mismatch, samples_checked;
    int          sel[6] = '{0, 1, 2, 0, 1, 0};
    avc_core avc_core_i (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(rs), .vfy_req_o(vreq),
        .vfy_lba_o(vlba), .vfy_done_i(vdone), .vfy_unc_i(vunc), .seek_req_o(sreq),
        .seek_done_i(sdone), .seek_fail_i(sfail), .user_pw_i(upw), .master_pw_i(mpw),
        .sec_en_o(sec_en));
    avc_media_model avc_media_model_i (.clock_i(clock_i), .reset_i(reset_i),
        .vfy_req_i(vreq), .vfy_lba_i(vlba), .seek_req_i(sreq), .delay_i(dly),
        .bad_lba_i(bad_lba), .bad_en_i(bad_en), .seek_bad_i(seek_bad), .vfy_done_o(vdone),
        .vfy_unc_o(vunc), .seek_done_o(sdone), .seek_fail_o(sfail));
    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; an idle edge first so psel is never set twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        // wait as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge clock_i);
        end while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll;
        int n;
        n = 0;
        do begin
            apb(1'b0, `AVC_OFF_STAT, 32'h0);
            n++;
        end while (rv[`AVC_ST_BSY] !== 1'b0 && n < 9000);
    endtask
    // load count and start lba as previous/current byte pairs, then run
    task automatic verify(input logic [47:0] l, input logic [15:0] c);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `AVC_OFF_SCNT + 8'(4 * i), i == 0 ? c[15:8] : l[8 * i + 16 +: 8]);
            apb(1'b1, `AVC_OFF_SCNT + 8'(4 * i), i == 0 ? c[7:0] : l[8 * i - 8 +: 8]);
        end
        apb(1'b1, `AVC_OFF_CMD, `AVC_CMD_VFY_EXT);
        poll;
    endtask
    function automatic logic [15:0] remain(input logic [15:0] c, input int off);
        return 16'(((c == 16'h0) ? 32'h10000 : 32'(c)) - off);
    endfunction
    // password sector with random reserved content
    task automatic sector(input logic id, input logic [255:0] p);
        logic [15:0] w;
        apb(1'b1, `AVC_OFF_CMD, `AVC_CMD_SEC_DIS);
        apb(1'b0, `AVC_OFF_STAT, 32'h0);
        chk(rv, 32'h58);
        for (int k = 0; k < 256; k++) begin
            w = 16'($urandom);
            if (k == 0) w[0] = id;
            else if (k <= 16) w = p[16 * k - 1 -: 16];
            apb(1'b1, `AVC_OFF_DATA, {16'($urandom), w});
        end
        poll;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        repeat (60000) @(posedge clock_i);
        n_mismatch++;
        conclude;
    end
    initial begin
        void'($urandom(32'h6F67));
        {reset_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {bad_en, seek_bad, dly, bad_lba} = '0;
        for (int i = 0; i < 8; i++) {upw[32 * i +: 32], mpw[32 * i +: 32]} = {$urandom, $urandom};
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        apb(1'b0, `AVC_OFF_STAT, 32'h0);
        chk(rv, 32'h50);
        apb(1'b0, `AVC_OFF_ERR, 32'h0);
        chk(rv, 32'h0);
        apb(1'b0, `AVC_OFF_SEC, 32'h0);
        chk(rv, 32'h1);
        apb(1'b0, 8'h28, 32'h0);
        chk(rs, 1'b1);
        // verify runs: failing at an offset, or clean with random values
        for (int t = 0; t < 5; t++) begin
            logic [47:0] l;
            logic [15:0] c;
            int off;
            l = (t == 0) ? 48'h00FF_FFFF_FFF0 : {16'($urandom), $urandom};
            c = (t == 0) ? 16'h0102 : (t == 1) ? 16'h0 : 16'($urandom_range(1, 5));
            off = (t == 0) ? 257 : 300;
            bad_en <= (t < 2);
            bad_lba <= l + 48'(off);
            dly <= 4'($urandom);
            verify(l, c);
            apb(1'b0, `AVC_OFF_STAT, 32'h0);
            chk(rv, t < 2 ? 32'h51 : 32'h50);
            apb(1'b1, `AVC_OFF_DEVCTL, 32'h0);
            apb(1'b0, `AVC_OFF_SCNT, 32'h0);
            chk(rv[7:0], 8'(t < 2 ? remain(c, off) : 16'h0));
            for (int i = 0; i < 6 && t < 2; i++) begin
                if (i == 3) apb(1'b1, `AVC_OFF_DEVCTL, 32'h80);
                apb(1'b0, `AVC_OFF_SNUM + 8'(4 * (i % 3)), 32'h0);
                chk(rv[7:0], bad_lba[8 * i +: 8]);
            end
            apb(1'b0, `AVC_OFF_SCNT, 32'h0);
            chk(rv[7:0], t < 2 ? 8'(remain(c, off) >> 8) : 8'h0);
        end
        // recalibrate, any low nibble, with and without a failed seek
        for (int t = 0; t < 4; t++) begin
            seek_bad <= t[0];
            dly <= 4'($urandom);
            apb(1'b1, `AVC_OFF_CMD, {24'h0, `AVC_CMD_RECAL, 4'($urandom)});
            poll;
            chk(rv, t[0] ? 32'h51 : 32'h50);
            apb(1'b0, `AVC_OFF_ERR, 32'h0);
            chk(rv, t[0] ? 32'h02 : 32'h00);
        end
        // a code outside 1xh, 42h and F6h is refused at once: no seek, abort
        apb(1'b1, `AVC_OFF_CMD, 32'h27);
        apb(1'b0, `AVC_OFF_STAT, 32'h0);
        chk(rv, 32'h51);
        apb(1'b0, `AVC_OFF_ERR, 32'h0);
        chk(rv, 32'h04);
        // password disable table: master, user while off, wrong, swapped, user, master again
        for (int k = 0; k < 6; k++) begin
            if (k == 2 || k == 5) apb(1'b1, `AVC_OFF_SEC, 32'h1);
            pw = (sel[k] == 0) ? mpw : (sel[k] == 1) ? upw : ~mpw;
            sector(1'(6'b100101 >> k), pw);
            chk(sec_en, (6'b001100 >> k) & 1'b1);
            apb(1'b0, `AVC_OFF_ERR, 32'h0);
            chk(rv, ((6'b001110 >> k) & 1'b1) ? 32'h04 : 32'h00);
        end
        apb(1'b0, `AVC_OFF_SEC, 32'h0);
        chk(rv, 32'h0);
        conclude;
    end
endmodule
`default_nettype wire
